// [phy_mgmt_pkg.sv]
// Purpose: shared constants for the backplane PHY management register bank
// Assumes: word addressed management bus, 32-bit data
// Notes: every offset and field position lives here; of the reset values only the AN control one does
package phy_mgmt_pkg;
	// word addresses
	localparam logic [7:0] SEQ_CTRL_ADDR = 8'hB0;
	localparam logic [7:0] SEQ_STAT_ADDR = 8'hB1;
	localparam logic [7:0] FEC_INJ_ADDR = 8'hB2;
	localparam logic [7:0] FEC_CORR_ADDR = 8'hB3;
	localparam logic [7:0] FEC_UNCORR_ADDR = 8'hB4;
	localparam logic [7:0] AN_CTRL_ADDR = 8'hC0;
	// sequencer control fields
	localparam int SEQ_RESET_BIT = 0;
	localparam int AN_TIMER_DIS_BIT = 1;
	localparam int LF_TIMER_DIS_BIT = 2;
	localparam int FORCE_LSB = 4;
	localparam int FORCE_MSB = 6;
	localparam int FEC_ABILITY_BIT = 16;
	localparam int FEC_ERR_IND_BIT = 17;
	localparam int FEC_REQ_BIT = 18;
	// sequencer status fields
	localparam int LINK_READY_BIT = 0;
	localparam int AN_TIMEOUT_BIT = 1;
	localparam int LT_TIMEOUT_BIT = 2;
	localparam int MODE_LSB = 8;
	localparam int MODE_MSB = 13;
	localparam int FEC_SUPPORT_BIT = 16;
	localparam int FEC_ERR_CAP_BIT = 17;
	// error injection fields
	localparam int INJ_TRANS_BIT = 0;
	localparam int INJ_BURST_BIT = 1;
	localparam int BURST_LEN_LSB = 2;
	localparam int BURST_LEN_MSB = 5;
	localparam int INJ_PULSE_BIT = 11;
	// auto-negotiation control fields
	localparam int AN_ENABLE_BIT = 0;
	localparam int AN_USER_BASE_BIT = 1;
	localparam int AN_USER_NEXT_BIT = 2;
	localparam int AN_RFAULT_BIT = 3;
	// writable masks and reset values
	localparam logic [31:0] SEQ_CTRL_MASK = 32'h0007_0076;
	localparam logic [31:0] FEC_INJ_MASK = 32'h0000_003F;
	localparam logic [31:0] AN_CTRL_MASK = 32'h0000_0007;
	localparam logic [31:0] AN_CTRL_RESET = 32'h0000_0001;
	// force mode codes
	localparam logic [2:0] FORCE_NONE = 3'h0;
	localparam logic [2:0] FORCE_GIGE = 3'h1;
	localparam logic [2:0] FORCE_10G = 3'h5;
	// one-hot pcs reconfiguration modes
	localparam logic [5:0] PCS_AN = 6'h01;
	localparam logic [5:0] PCS_LT = 6'h02;
	localparam logic [5:0] PCS_10G = 6'h04;
	localparam logic [5:0] PCS_GIGE = 6'h08;
	localparam logic [5:0] PCS_10G_FEC = 6'h20;
	// equaliser mode codes
	localparam logic [1:0] DFE_OFF = 2'h0;
	localparam logic [1:0] DFE_TRIGGERED = 2'h1;
	localparam logic [1:0] LINEAR_EQ_FROM_LT = 2'h0;
endpackage : phy_mgmt_pkg

// [sat_counter.sv]
// Purpose: saturating event counter cleared by a read
// Assumes: increment and clear come from the management clock domain
// Notes: an event in the clearing cycle is kept as a count of one
`timescale 1ns/1ps
module sat_counter #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic inc_i,
	input wire logic clr_i,
	// value
	output logic [WIDTH-1:0] count_o
);
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;

	initial begin
		if (WIDTH < 1) $error("sat_counter width must be positive");
	end

	// saturate instead of wrapping so a long soak never reports a small count
	always_comb begin
		count_d = count_q;
		if (clr_i) begin
			count_d = inc_i ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
		end else if (inc_i && (count_q != {WIDTH{1'b1}})) begin
			count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) count_q <= '0;
		else count_q <= count_d;
	end

	assign count_o = count_q;
endmodule : sat_counter

// [backplane_phy_mgmt_regs.sv]
// Purpose: management register bank of a backplane Ethernet PHY
// Assumes: word addressed bus with read/write strobes and waitrequest
// Notes: sequencer, FEC and auto-negotiation cores sit outside this block
`timescale 1ns/1ps
module backplane_phy_mgmt_regs #(
	parameter int ADDR_WIDTH = 8,
	parameter int DATA_WIDTH = 32,
	parameter int LINEAR_EQ_WIDTH = 4,
	parameter bit FEC_ABILITY_ON_RESET = 1'b1
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic mgmt_clk_reset_i,
	// management bus
	input wire logic [ADDR_WIDTH-1:0] mgmt_addr_i,
	input wire logic [DATA_WIDTH-1:0] mgmt_writedata_i,
	input wire logic mgmt_write_i,
	input wire logic mgmt_read_i,
	output logic [DATA_WIDTH-1:0] mgmt_readdata_o,
	output logic mgmt_waitrequest_o,
	// sequencer status from the core
	input wire logic link_ready_i,
	input wire logic an_timeout_i,
	input wire logic lt_timeout_i,
	input wire logic an_restart_i,
	input wire logic [5:0] pcs_mode_i,
	input wire logic fec_supported_i,
	input wire logic fec_err_ind_capable_i,
	input wire logic local_remote_fault_i,
	// FEC block events, one pulse per block
	input wire logic fec_block_corrected_i,
	input wire logic fec_block_uncorrected_i,
	// sequencer control to the core
	output logic seq_reset_o,
	output logic [2:0] seq_force_mode_o,
	output logic an_timer_disable_o,
	output logic link_fault_timer_disable_o,
	output logic fec_ability_o,
	output logic fec_err_ind_en_o,
	output logic fec_request_o,
	output logic speed_low_rate_o,
	// FEC error injection
	output logic inj_trans_en_o,
	output logic inj_burst_en_o,
	output logic [3:0] inj_burst_len_o,
	output logic inj_pulse_o,
	// auto-negotiation control
	output logic an_enable_o,
	output logic an_user_base_pages_o,
	output logic an_user_next_pages_o,
	// receive equalisation reconfiguration
	input wire logic eq_request_i,
	input wire logic dfe_enable_i,
	input wire logic [LINEAR_EQ_WIDTH-1:0] lt_linear_eq_i,
	input wire logic reconfig_in_progress_i,
	input wire logic rx_eq_done_i,
	input wire logic speed_select_low_rate_i,
	input wire logic auto_speed_detect_i,
	output logic rx_eq_feedback_start_req_o,
	output logic [1:0] rx_eq_feedback_mode_o,
	output logic linear_eq_start_req_o,
	output logic [1:0] linear_eq_mode_o,
	output logic [LINEAR_EQ_WIDTH-1:0] linear_eq_value_o,
	output logic eq_ready_o
);
	typedef enum logic [1:0] {
		EQ_IDLE = 2'b00,
		EQ_WAIT_BUSY = 2'b01,
		EQ_BUSY = 2'b11
	} eq_state_t;

	logic rst_meta_q;
	logic rst_q;
	logic rst_req;
	logic rst;
	logic busy_meta_q;
	logic busy_q;
	logic speed_meta_q;
	logic speed_q;
	logic done_meta_q;
	logic done_q;
	logic wr_ack_q;
	logic rd_ack_q;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] seq_ctrl_q;
	logic [31:0] fec_inj_q;
	logic [31:0] an_ctrl_q;
	logic seq_reset_q;
	logic inj_pulse_q;
	logic an_timeout_q;
	logic [31:0] seq_stat;
	logic [31:0] corr_count;
	logic [31:0] uncorr_count;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic clr_corr;
	logic clr_uncorr;
	eq_state_t eq_state_q;
	eq_state_t eq_state_d;
	logic dfe_start_q;
	logic lin_start_q;
	logic [1:0] dfe_mode_q;
	logic [LINEAR_EQ_WIDTH-1:0] lin_value_q;

	initial begin
		if (ADDR_WIDTH != 8) $error("address width must be 8");
		if (DATA_WIDTH != 32) $error("data width must be 32");
		if (LINEAR_EQ_WIDTH != 4) $error("linear equaliser value is 4 bits");
	end

	// address compare used by both read and write paths
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction : hit

	// reset: pin reset and level reset assert at once; both release through two stages
	// so a level reset dropping near a clock edge cannot leave flops half released
	assign rst_req = ~arst_n_i | mgmt_clk_reset_i;
	always_ff @(posedge mclk_i or posedge rst_req) begin
		if (rst_req) begin
			rst_meta_q <= 1'b1;
			rst_q <= 1'b1;
		end else begin
			rst_meta_q <= 1'b0;
			rst_q <= rst_meta_q;
		end
	end
	assign rst = rst_q;

	// synchronise inputs driven from other clock domains
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) begin
			busy_meta_q <= 1'b0;
			busy_q <= 1'b0;
			speed_meta_q <= 1'b0;
			speed_q <= 1'b0;
			done_meta_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			busy_meta_q <= reconfig_in_progress_i;
			busy_q <= busy_meta_q;
			speed_meta_q <= speed_select_low_rate_i;
			speed_q <= speed_meta_q;
			done_meta_q <= rx_eq_done_i;
			done_q <= done_meta_q;
		end
	end

	// one wait cycle per access; the master must hold the request meanwhile
	assign wr_fire = mgmt_write_i & ~wr_ack_q;
	assign rd_fire = mgmt_read_i & ~mgmt_write_i & ~rd_ack_q;
	assign mgmt_waitrequest_o = wr_fire | rd_fire;

	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) begin
			wr_ack_q <= 1'b0;
			rd_ack_q <= 1'b0;
		end else begin
			wr_ack_q <= wr_fire;
			rd_ack_q <= rd_fire;
		end
	end

	// sequencer control: masked so reserved bits never store
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) begin
			seq_ctrl_q <= 32'h0000_0000;
			seq_ctrl_q[phy_mgmt_pkg::FEC_ABILITY_BIT] <= FEC_ABILITY_ON_RESET;
		end else if (wr_fire && hit(mgmt_addr_i, phy_mgmt_pkg::SEQ_CTRL_ADDR)) begin
			seq_ctrl_q <= mgmt_writedata_i & phy_mgmt_pkg::SEQ_CTRL_MASK;
		end
	end

	// self-clearing sequencer reset pulse
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) seq_reset_q <= 1'b0;
		else seq_reset_q <= wr_fire && hit(mgmt_addr_i, phy_mgmt_pkg::SEQ_CTRL_ADDR)
			&& mgmt_writedata_i[phy_mgmt_pkg::SEQ_RESET_BIT];
	end

	// force mode is latched only at a sequencer reset so it cannot glitch a run
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) seq_force_mode_o <= phy_mgmt_pkg::FORCE_NONE;
		else if (seq_reset_q) seq_force_mode_o <=
			seq_ctrl_q[phy_mgmt_pkg::FORCE_MSB:phy_mgmt_pkg::FORCE_LSB];
	end

	assign seq_reset_o = seq_reset_q;
	assign an_timer_disable_o = seq_ctrl_q[phy_mgmt_pkg::AN_TIMER_DIS_BIT];
	assign link_fault_timer_disable_o = seq_ctrl_q[phy_mgmt_pkg::LF_TIMER_DIS_BIT];
	assign fec_ability_o = seq_ctrl_q[phy_mgmt_pkg::FEC_ABILITY_BIT];
	assign fec_err_ind_en_o = seq_ctrl_q[phy_mgmt_pkg::FEC_ERR_IND_BIT];
	assign fec_request_o = seq_ctrl_q[phy_mgmt_pkg::FEC_REQ_BIT];

	// pin speed select only matters when the sequencer is not detecting speed
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) speed_low_rate_o <= 1'b0;
		else if (!auto_speed_detect_i) speed_low_rate_o <= speed_q;
	end

	// latched AN timeout; a new timeout wins over the restart clear
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) an_timeout_q <= 1'b0;
		else if (an_timeout_i) an_timeout_q <= 1'b1;
		else if (an_restart_i) an_timeout_q <= 1'b0;
	end

	// status word assembly
	always_comb begin
		seq_stat = 32'h0000_0000;
		seq_stat[phy_mgmt_pkg::LINK_READY_BIT] = link_ready_i;
		seq_stat[phy_mgmt_pkg::AN_TIMEOUT_BIT] = an_timeout_q;
		seq_stat[phy_mgmt_pkg::LT_TIMEOUT_BIT] = lt_timeout_i;
		seq_stat[phy_mgmt_pkg::MODE_MSB:phy_mgmt_pkg::MODE_LSB] = pcs_mode_i;
		seq_stat[phy_mgmt_pkg::FEC_SUPPORT_BIT] = fec_supported_i;
		seq_stat[phy_mgmt_pkg::FEC_ERR_CAP_BIT] = fec_err_ind_capable_i;
	end

	// error injection settings
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) fec_inj_q <= 32'h0000_0000;
		else if (wr_fire && hit(mgmt_addr_i, phy_mgmt_pkg::FEC_INJ_ADDR))
			fec_inj_q <= mgmt_writedata_i & phy_mgmt_pkg::FEC_INJ_MASK;
	end

	// injection pulse lasts one cycle per write of a one
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) inj_pulse_q <= 1'b0;
		else inj_pulse_q <= wr_fire && hit(mgmt_addr_i, phy_mgmt_pkg::FEC_INJ_ADDR)
			&& mgmt_writedata_i[phy_mgmt_pkg::INJ_PULSE_BIT];
	end

	assign inj_trans_en_o = fec_inj_q[phy_mgmt_pkg::INJ_TRANS_BIT];
	assign inj_burst_en_o = fec_inj_q[phy_mgmt_pkg::INJ_BURST_BIT];
	assign inj_burst_len_o = fec_inj_q[phy_mgmt_pkg::BURST_LEN_MSB:phy_mgmt_pkg::BURST_LEN_LSB];
	assign inj_pulse_o = inj_pulse_q;

	// block counters cleared by the read that returns them
	assign clr_corr = rd_fire && hit(mgmt_addr_i, phy_mgmt_pkg::FEC_CORR_ADDR);
	assign clr_uncorr = rd_fire && hit(mgmt_addr_i, phy_mgmt_pkg::FEC_UNCORR_ADDR);

	sat_counter #(.WIDTH(32)) u_corr (
		.clk_i(mclk_i),
		.rst_i(rst),
		.inc_i(fec_block_corrected_i),
		.clr_i(clr_corr),
		.count_o(corr_count)
	);

	sat_counter #(.WIDTH(32)) u_uncorr (
		.clk_i(mclk_i),
		.rst_i(rst),
		.inc_i(fec_block_uncorrected_i),
		.clr_i(clr_uncorr),
		.count_o(uncorr_count)
	);

	// auto-negotiation control, enable comes up set
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) an_ctrl_q <= phy_mgmt_pkg::AN_CTRL_RESET;
		else if (wr_fire && hit(mgmt_addr_i, phy_mgmt_pkg::AN_CTRL_ADDR))
			an_ctrl_q <= mgmt_writedata_i & phy_mgmt_pkg::AN_CTRL_MASK;
	end

	assign an_enable_o = an_ctrl_q[phy_mgmt_pkg::AN_ENABLE_BIT];
	assign an_user_base_pages_o = an_ctrl_q[phy_mgmt_pkg::AN_USER_BASE_BIT];
	assign an_user_next_pages_o = an_ctrl_q[phy_mgmt_pkg::AN_USER_NEXT_BIT];

	// read multiplexer; unmapped addresses answer zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (mgmt_addr_i)
			phy_mgmt_pkg::SEQ_CTRL_ADDR: rdata_d = seq_ctrl_q;
			phy_mgmt_pkg::SEQ_STAT_ADDR: rdata_d = seq_stat;
			phy_mgmt_pkg::FEC_INJ_ADDR: rdata_d = fec_inj_q;
			phy_mgmt_pkg::FEC_CORR_ADDR: rdata_d = corr_count;
			phy_mgmt_pkg::FEC_UNCORR_ADDR: rdata_d = uncorr_count;
			phy_mgmt_pkg::AN_CTRL_ADDR: begin
				rdata_d = an_ctrl_q;
				rdata_d[phy_mgmt_pkg::AN_RFAULT_BIT] = local_remote_fault_i;
			end
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// read data captured in the wait cycle, valid when waitrequest drops
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) rdata_q <= 32'h0000_0000;
		else if (rd_fire) rdata_q <= rdata_d;
	end
	assign mgmt_readdata_o = rdata_q;

	// equaliser request sequencer: idle, wait for busy rise, wait for busy fall
	always_comb begin
		eq_state_d = eq_state_q;
		case (eq_state_q)
			EQ_IDLE: if (eq_request_i && done_q) eq_state_d = EQ_WAIT_BUSY;
			EQ_WAIT_BUSY: if (busy_q) eq_state_d = EQ_BUSY;
			EQ_BUSY: if (!busy_q) eq_state_d = EQ_IDLE;
			default: eq_state_d = EQ_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) eq_state_q <= EQ_IDLE;
		else eq_state_q <= eq_state_d;
	end

	// start pulses and values; values only move in idle so they hold until busy falls
	always_ff @(posedge mclk_i or posedge rst) begin
		if (rst) begin
			dfe_start_q <= 1'b0;
			lin_start_q <= 1'b0;
			dfe_mode_q <= phy_mgmt_pkg::DFE_OFF;
			lin_value_q <= '0;
		end else begin
			dfe_start_q <= 1'b0;
			lin_start_q <= 1'b0;
			if (eq_state_q == EQ_IDLE && eq_request_i && done_q) begin
				dfe_start_q <= dfe_enable_i;
				lin_start_q <= ~dfe_enable_i;
				dfe_mode_q <= dfe_enable_i ? phy_mgmt_pkg::DFE_TRIGGERED
					: phy_mgmt_pkg::DFE_OFF;
				lin_value_q <= lt_linear_eq_i;
			end
		end
	end

	assign rx_eq_feedback_start_req_o = dfe_start_q;
	assign rx_eq_feedback_mode_o = dfe_mode_q;
	assign linear_eq_start_req_o = lin_start_q;
	assign linear_eq_mode_o = phy_mgmt_pkg::LINEAR_EQ_FROM_LT;
	assign linear_eq_value_o = lin_value_q;
	assign eq_ready_o = (eq_state_q == EQ_IDLE) & done_q;
endmodule : backplane_phy_mgmt_regs

// [phy_mgmt_chk.sv]
// Purpose: port checker for the phy management register bank
// Assumes: one clock domain, either reset input disables checking
// Notes: attached by the bind after the module
`timescale 1ns/1ps
module phy_mgmt_chk #(
	parameter int ADDR_WIDTH = 8,
	parameter int DATA_WIDTH = 32,
	parameter int LINEAR_EQ_WIDTH = 4
) (
	// clock and resets
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic mgmt_clk_reset_i,
	// management bus
	input wire logic [ADDR_WIDTH-1:0] mgmt_addr_i,
	input wire logic [DATA_WIDTH-1:0] mgmt_writedata_i,
	input wire logic mgmt_write_i,
	input wire logic mgmt_read_i,
	input wire logic [DATA_WIDTH-1:0] mgmt_readdata_o,
	input wire logic mgmt_waitrequest_o,
	// core side
	input wire logic [5:0] pcs_mode_i,
	input wire logic [LINEAR_EQ_WIDTH-1:0] lt_linear_eq_i,
	input wire logic seq_reset_o,
	input wire logic [2:0] seq_force_mode_o,
	input wire logic an_timer_disable_o,
	input wire logic inj_pulse_o,
	input wire logic rx_eq_feedback_start_req_o,
	input wire logic [1:0] rx_eq_feedback_mode_o,
	input wire logic linear_eq_start_req_o,
	input wire logic [1:0] linear_eq_mode_o,
	input wire logic [LINEAR_EQ_WIDTH-1:0] linear_eq_value_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i || mgmt_clk_reset_i);
	// an access is taken while waitrequest is still high
	logic wr_take;
	logic rd_take;
	logic tmr_wr;
	assign wr_take = mgmt_write_i && mgmt_waitrequest_o;
	assign rd_take = mgmt_read_i && mgmt_waitrequest_o;
	assign tmr_wr = wr_take && mgmt_addr_i == 8'hB0 && mgmt_writedata_i[1];
	// single-cycle command pulses
	sequence s_seq_pulse;
		seq_reset_o ##1 !seq_reset_o;
	endsequence
	sequence s_inj_pulse;
		inj_pulse_o ##1 !inj_pulse_o;
	endsequence
	a_wait_one_cycle: assert property ($rose(mgmt_write_i) || $rose(mgmt_read_i)
		|-> mgmt_waitrequest_o ##1 !mgmt_waitrequest_o) else $error("wait not one cycle");
	a_seq_reset_pulse: assert property (wr_take && mgmt_addr_i == 8'hB0
		&& mgmt_writedata_i[0] |=> s_seq_pulse) else $error("sequencer reset pulse wrong");
	a_force_load: assert property (seq_reset_o
		|=> seq_force_mode_o == $past(mgmt_writedata_i[6:4], 2)) else $error("force not loaded");
	a_force_held: assert property (!$past(seq_reset_o) |-> $stable(seq_force_mode_o))
		else $error("force changed without reset");
	a_inj_pulse: assert property (wr_take && mgmt_addr_i == 8'hB2
		&& mgmt_writedata_i[11] |=> s_inj_pulse) else $error("inject pulse wrong");
	a_timer_cause: assert property ($rose(an_timer_disable_o) |-> $past(tmr_wr))
		else $error("timer disable without write");
	a_unmapped_zero: assert property (rd_take && (mgmt_addr_i < 8'hB0
		|| mgmt_addr_i > 8'hC0) |=> mgmt_readdata_o == '0) else $error("unmapped read not 0");
	a_status_mode: assert property (rd_take && mgmt_addr_i == 8'hB1
		|=> mgmt_readdata_o[13:8] == $past(pcs_mode_i)) else $error("mode field wrong");
	a_dfe_hold: assert property (rx_eq_feedback_start_req_o
		|=> $stable(rx_eq_feedback_mode_o) [*4]) else $error("feedback mode not held");
	a_linear_start: assert property (linear_eq_start_req_o |-> linear_eq_mode_o == 2'h0
		&& linear_eq_value_o == $past(lt_linear_eq_i) ##1 $stable(linear_eq_value_o) [*4])
		else $error("linear value wrong");
endmodule : phy_mgmt_chk

bind backplane_phy_mgmt_regs phy_mgmt_chk #(
	.ADDR_WIDTH(ADDR_WIDTH),
	.DATA_WIDTH(DATA_WIDTH),
	.LINEAR_EQ_WIDTH(LINEAR_EQ_WIDTH)
) u_chk (
	.mclk_i(mclk_i), .arst_n_i(arst_n_i), .mgmt_clk_reset_i(mgmt_clk_reset_i),
	.mgmt_addr_i(mgmt_addr_i), .mgmt_writedata_i(mgmt_writedata_i),
	.mgmt_write_i(mgmt_write_i), .mgmt_read_i(mgmt_read_i),
	.mgmt_readdata_o(mgmt_readdata_o), .mgmt_waitrequest_o(mgmt_waitrequest_o),
	.pcs_mode_i(pcs_mode_i), .lt_linear_eq_i(lt_linear_eq_i), .seq_reset_o(seq_reset_o),
	.seq_force_mode_o(seq_force_mode_o), .an_timer_disable_o(an_timer_disable_o),
	.inj_pulse_o(inj_pulse_o), .rx_eq_feedback_start_req_o(rx_eq_feedback_start_req_o),
	.rx_eq_feedback_mode_o(rx_eq_feedback_mode_o),
	.linear_eq_start_req_o(linear_eq_start_req_o), .linear_eq_mode_o(linear_eq_mode_o),
	.linear_eq_value_o(linear_eq_value_o)
);

// [phy_mgmt_host.sv]
// Purpose: management bus master model with access tasks
// Assumes: one wait cycle or more, word addresses
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module phy_mgmt_host (
	// clock
	input wire logic mclk_i,
	// management bus, master side
	output logic [7:0] mgmt_addr_o,
	output logic [31:0] mgmt_writedata_o,
	output logic mgmt_write_o,
	output logic mgmt_read_o,
	input wire logic [31:0] mgmt_readdata_i,
	input wire logic mgmt_waitrequest_i,
	// hang flag
	output logic stuck_o
);
	initial begin
		{mgmt_addr_o, mgmt_writedata_o, mgmt_write_o, mgmt_read_o, stuck_o} = '0;
	end
	// one access, held until waitrequest is seen low; bounded so a hang cannot stall us
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		int n;
		n = 0;
		@(posedge mclk_i);
		mgmt_addr_o <= addr;
		mgmt_writedata_o <= wdata;
		mgmt_write_o <= wr;
		mgmt_read_o <= !wr;
		do begin
			@(posedge mclk_i);
			n++;
		end while (mgmt_waitrequest_i !== 1'b0 && n < 16);
		rdata = mgmt_readdata_i;
		mgmt_write_o <= 1'b0;
		mgmt_read_o <= 1'b0;
		mgmt_addr_o <= ~addr;
		mgmt_writedata_o <= ~wdata;
		if (n >= 16) stuck_o = 1'b1;
	endtask : xfer
	// masked fields change by read-modify-write; other bits are written back as read
	task automatic rmw(input logic [7:0] addr, input logic [31:0] set_m, input logic [31:0] clr_m);
		logic [31:0] v;
		xfer(1'b0, addr, '0, v);
		xfer(1'b1, addr, (v & ~clr_m) | set_m, v);
	endtask : rmw
endmodule : phy_mgmt_host

// [backplane_phy_mgmt_regs_test.sv]
// Purpose: self-checking bench for the phy management register bank
// Assumes: host model drives the bus, bench drives the core side
// Notes: equaliser done is tied high as the integration requires
`timescale 1ns/1ps
module backplane_phy_mgmt_regs_test;
	logic mclk_i, arst_n_i, mgmt_clk_reset_i, wr_s, rd_s, wait_s, host_stuck;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic link_ready_i, an_timeout_i, lt_timeout_i, an_restart_i, fec_sup_i, fec_cap_i, lrf_i;
	logic corr_i, uncorr_i, eq_request_i, dfe_enable_i, busy_i, speed_i, auto_i;
	logic [5:0] pcs_mode_i;
	logic [3:0] lt_linear_eq_i, inj_len, lin_val;
	logic seq_reset_o, an_tmr, lf_tmr, fec_abil, fec_err, fec_req, speed_o, inj_trans, inj_burst;
	logic inj_pulse, an_en, an_base, an_next, dfe_start, lin_start, eq_ready;
	logic [2:0] force_o;
	logic [1:0] dfe_mode, lin_mode;
	logic [2:0] codes [3];
	int errors = 0;
	int comparisons = 0;
	phy_mgmt_host u_host (.mclk_i(mclk_i), .mgmt_addr_o(addr), .mgmt_writedata_o(wdata),
		.mgmt_write_o(wr_s), .mgmt_read_o(rd_s), .mgmt_readdata_i(rdata),
		.mgmt_waitrequest_i(wait_s), .stuck_o(host_stuck));
	backplane_phy_mgmt_regs u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.mgmt_clk_reset_i(mgmt_clk_reset_i), .mgmt_addr_i(addr), .mgmt_writedata_i(wdata),
		.mgmt_write_i(wr_s), .mgmt_read_i(rd_s), .mgmt_readdata_o(rdata),
		.mgmt_waitrequest_o(wait_s), .link_ready_i(link_ready_i), .an_timeout_i(an_timeout_i),
		.lt_timeout_i(lt_timeout_i), .an_restart_i(an_restart_i), .pcs_mode_i(pcs_mode_i),
		.fec_supported_i(fec_sup_i), .fec_err_ind_capable_i(fec_cap_i),
		.local_remote_fault_i(lrf_i), .fec_block_corrected_i(corr_i),
		.fec_block_uncorrected_i(uncorr_i), .seq_reset_o(seq_reset_o),
		.seq_force_mode_o(force_o), .an_timer_disable_o(an_tmr),
		.link_fault_timer_disable_o(lf_tmr), .fec_ability_o(fec_abil),
		.fec_err_ind_en_o(fec_err), .fec_request_o(fec_req), .speed_low_rate_o(speed_o),
		.inj_trans_en_o(inj_trans), .inj_burst_en_o(inj_burst), .inj_burst_len_o(inj_len),
		.inj_pulse_o(inj_pulse), .an_enable_o(an_en), .an_user_base_pages_o(an_base),
		.an_user_next_pages_o(an_next), .eq_request_i(eq_request_i),
		.dfe_enable_i(dfe_enable_i), .lt_linear_eq_i(lt_linear_eq_i),
		.reconfig_in_progress_i(busy_i), .rx_eq_done_i(1'b1),
		.speed_select_low_rate_i(speed_i), .auto_speed_detect_i(auto_i),
		.rx_eq_feedback_start_req_o(dfe_start), .rx_eq_feedback_mode_o(dfe_mode),
		.linear_eq_start_req_o(lin_start), .linear_eq_mode_o(lin_mode),
		.linear_eq_value_o(lin_val), .eq_ready_o(eq_ready));
	// free-running management clock
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		u_host.xfer(1'b0, a, '0, v);
		check(v, exp);
	endtask : rd_chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		u_host.xfer(1'b1, a, d, v);
	endtask : wr
	// one equaliser request; busy held long enough to cover the sync delay
	task automatic eq_run(input logic dfe, input logic [3:0] val);
		@(posedge mclk_i);
		check({31'h0, eq_ready}, 32'h1);
		dfe_enable_i <= dfe;
		lt_linear_eq_i <= val;
		eq_request_i <= 1'b1;
		@(posedge mclk_i);
		eq_request_i <= 1'b0;
		@(posedge mclk_i);
		if (dfe) check({29'h0, dfe_start, dfe_mode}, 32'h5);
		else check({25'h0, lin_start, lin_mode, lin_val}, {25'h0, 3'h4, val});
		busy_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		busy_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
	endtask : eq_run
	task automatic close_out;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	// watchdog, far beyond the two hundred or so cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk_i);
		errors++;
		$display("watchdog expired");
		close_out();
	end
	initial begin
		codes = '{phy_mgmt_pkg::FORCE_10G, phy_mgmt_pkg::FORCE_GIGE, phy_mgmt_pkg::FORCE_NONE};
		{arst_n_i, mgmt_clk_reset_i, link_ready_i, an_timeout_i, lt_timeout_i, an_restart_i} = '0;
		{fec_sup_i, fec_cap_i, lrf_i, corr_i, uncorr_i, eq_request_i, dfe_enable_i} = '0;
		{busy_i, speed_i, auto_i, pcs_mode_i, lt_linear_eq_i} = '0;
		repeat (8) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		rd_chk(8'hB0, 32'h0001_0000);
		rd_chk(8'hB2, 32'h0);
		rd_chk(8'hB3, 32'h0);
		rd_chk(8'hC0, 32'h1);
		$display("test reset_values done");
		wr(8'hB0, 32'hFFFF_FFFE);
		rd_chk(8'hB0, 32'h0007_0076);
		check({29'h0, force_o}, 32'h0);
		check({27'h0, an_tmr, lf_tmr, fec_abil, fec_err, fec_req}, 32'h1F);
		foreach (codes[i]) begin
			wr(8'hB0, {13'h0, 3'h7, 9'h0, codes[i], 4'h1});
			check({31'h0, seq_reset_o}, 32'h1);
			@(posedge mclk_i);
			check({29'h0, force_o}, {29'h0, codes[i]});
			rd_chk(8'hB0, {13'h0, 3'h7, 9'h0, codes[i], 4'h0});
		end
		$display("test sequencer_control done");
		{link_ready_i, lt_timeout_i, fec_sup_i, fec_cap_i, an_timeout_i} <= 5'h1F;
		@(posedge mclk_i);
		an_timeout_i <= 1'b0;
		rd_chk(8'hB1, 32'h0003_0007);
		an_restart_i <= 1'b1;
		@(posedge mclk_i);
		an_restart_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			pcs_mode_i <= 6'h1 << i;
			rd_chk(8'hB1, 32'h0003_0005 | (32'h100 << i));
		end
		$display("test sequencer_status done");
		wr(8'hB2, 32'hFFFF_FFFF);
		check({31'h0, inj_pulse}, 32'h1);
		rd_chk(8'hB2, 32'h0000_003F);
		check({26'h0, inj_trans, inj_burst, inj_len}, 32'h3F);
		$display("test error_injection done");
		repeat (3) begin
			@(posedge mclk_i);
			{corr_i, uncorr_i} <= 2'h3;
			@(posedge mclk_i);
			{corr_i, uncorr_i} <= 2'h0;
		end
		rd_chk(8'hB3, 32'h3);
		rd_chk(8'hB3, 32'h0);
		rd_chk(8'hB4, 32'h3);
		rd_chk(8'hB4, 32'h0);
		$display("test block_counters done");
		u_host.rmw(8'hC0, 32'h6, 32'h1);
		lrf_i <= 1'b1;
		rd_chk(8'hC0, 32'hE);
		check({29'h0, an_en, an_base, an_next}, 32'h3);
		wr(8'h10, 32'hFFFF_FFFF);
		rd_chk(8'h10, 32'h0);
		$display("test autoneg_and_unmapped done");
		speed_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		check({31'h0, speed_o}, 32'h1);
		{auto_i, speed_i} <= 2'h2;
		repeat (5) @(posedge mclk_i);
		check({31'h0, speed_o}, 32'h1);
		eq_run(1'b1, 4'h0);
		eq_run(1'b0, 4'hF);
		eq_run(1'b0, 4'h5);
		$display("test speed_and_equaliser done");
		mgmt_clk_reset_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		mgmt_clk_reset_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		rd_chk(8'hC0, 32'h9);
		rd_chk(8'hB0, 32'h0001_0000);
		check({31'h0, host_stuck}, 32'h0);
		$display("test level_reset done");
		close_out();
	end
endmodule : backplane_phy_mgmt_regs_test
